// ==== design/fesw_ctl.sv ====
// host controller that suspends, reads through and resumes a flash block erase
`timescale 1ns/10ps
`default_nettype none
`include "fesw_regs.svh"
module fesw_ctl (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // user requests and status
   input wire logic suspend_req_i,
   input wire logic resume_req_i,
   input wire logic read_req_i,
   input wire logic [16:0] read_addr_i,
   input wire logic boot_unlock_i,
   output logic busy_o,
   output logic done_o,
   output logic paused_o,
   output logic ignored_o,
   output logic [7:0] rd_data_o,
   // flash pins
   output logic [16:0] flash_addr_o,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe_o,
   input wire logic [7:0] flash_dq_i,
   output logic flash_ce_n_o,
   output logic flash_we_n_o,
   output logic flash_oe_n_o,
   output logic flash_oe_vhh_o,
   output logic powerdown_reset_n_o
);
   localparam logic [7:0] T_STROBE = 8'(`FESW_CYC(`FESW_T_STROBE_NS));
   localparam logic [7:0] T_RECOVERY = 8'(`FESW_CYC(`FESW_T_RECOVERY_NS));
   localparam logic [7:0] T_VHH_SETUP = 8'(`FESW_CYC(`FESW_T_VHH_SETUP_NS));
   localparam logic [7:0] T_VHH_HOLD = 8'(`FESW_CYC(`FESW_T_VHH_HOLD_NS));

   // ==========================================================
   // input synchroniser
   fesw_sync_if sif ();
   assign sif.data_raw = flash_dq_i;
   fesw_sync #(.WIDTH(8)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .bus(sif)
   );

   // ==========================================================
   // state
   typedef struct packed {
      fesw_pkg::fesw_state_t st;
      fesw_pkg::fesw_op_t op;
      logic [1:0] phase;
      logic [7:0] cnt;
      logic erasing;
      logic in_array;
      logic busy;
      logic done;
      logic paused;
      logic ignored;
      logic [7:0] rd_data;
      logic [16:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic oe_vhh;
      logic pd_n;
   } fesw_st_t;

   fesw_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.ignored = 1'b0;
      if (s_q.cnt != 8'h00) begin
         s_d.cnt = s_q.cnt - 8'h01;
      end
      case (s_q.st)
         fesw_pkg::FESW_IDLE: begin
            // recovery after powerdown release has elapsed in RECOVER
            if (suspend_req_i) begin
               if (!s_q.erasing || s_q.paused) begin
                  s_d.ignored = 1'b1;
                  s_d.done = 1'b1;
               end else begin
                  s_d.op = fesw_pkg::FESW_OP_SUSPEND;
                  s_d.dq = `FESW_CMD_SUSPEND;
                  s_d.st = fesw_pkg::FESW_SETUP;
               end
            end else if (resume_req_i) begin
               s_d.op = fesw_pkg::FESW_OP_RESUME;
               s_d.dq = `FESW_CMD_RESUME;
               s_d.st = fesw_pkg::FESW_SETUP;
            end else if (read_req_i) begin
               s_d.op = fesw_pkg::FESW_OP_READ;
               s_d.addr = read_addr_i;
               if (!s_q.in_array) begin
                  s_d.dq = `FESW_CMD_READ_ARRAY;
                  s_d.st = fesw_pkg::FESW_SETUP;
               end else begin
                  s_d.st = fesw_pkg::FESW_RD_SETUP;
                  s_d.cnt = T_STROBE;
               end
            end
            if (s_d.st == fesw_pkg::FESW_SETUP) begin
               s_d.busy = 1'b1;
               s_d.dq_oe = 1'b1;
               // with the unlock voltage the write strobe waits until the gate has settled
               s_d.we_n = boot_unlock_i;
               s_d.oe_vhh = boot_unlock_i;
               s_d.cnt = boot_unlock_i ? T_VHH_SETUP : T_STROBE;
            end else if (s_d.st == fesw_pkg::FESW_RD_SETUP) begin
               s_d.busy = 1'b1;
            end
         end
         fesw_pkg::FESW_SETUP: begin
            if (s_q.cnt == 8'h00 && s_q.we_n == 1'b1) begin
               s_d.we_n = 1'b0;
               s_d.cnt = T_STROBE;
            end else if (s_q.cnt == 8'h00) begin
               s_d.ce_n = 1'b0;
               s_d.cnt = T_STROBE;
               s_d.st = fesw_pkg::FESW_STROBE;
            end
         end
         fesw_pkg::FESW_STROBE: begin
            if (s_q.cnt == 8'h00) begin
               // the flash latches address and data on this rise
               s_d.ce_n = 1'b1;
               s_d.cnt = T_STROBE;
               s_d.st = fesw_pkg::FESW_HOLD;
            end
         end
         fesw_pkg::FESW_HOLD: begin
            if (s_q.cnt == 8'h00 && s_q.we_n == 1'b0) begin
               s_d.we_n = 1'b1;
               s_d.dq_oe = 1'b0;
               s_d.cnt = s_q.oe_vhh ? T_VHH_HOLD : 8'h01;
            end else if (s_q.cnt == 8'h00) begin
               s_d.oe_vhh = 1'b0;
               s_d.in_array = (s_q.op == fesw_pkg::FESW_OP_READ);
               s_d.phase = 2'h0;
               s_d.cnt = T_STROBE;
               s_d.st = fesw_pkg::FESW_RD_SETUP;
               if (s_q.op == fesw_pkg::FESW_OP_RESUME) begin
                  s_d.paused = 1'b0;
               end
            end
         end
         fesw_pkg::FESW_RD_SETUP: begin
            s_d.ce_n = 1'b0;
            s_d.oe_n = 1'b0;
            if (s_q.cnt == 8'h00) begin
               s_d.cnt = 8'h03;
               s_d.st = fesw_pkg::FESW_RD_SAMPLE;
            end
         end
         fesw_pkg::FESW_RD_SAMPLE: begin
            // wait out the synchroniser before sampling
            if (s_q.cnt == 8'h00) begin
               s_d.ce_n = 1'b1;
               s_d.oe_n = 1'b1;
               s_d.cnt = T_STROBE;
               s_d.st = fesw_pkg::FESW_RD_GAP;
               if (s_q.op == fesw_pkg::FESW_OP_READ) begin
                  s_d.rd_data = sif.data_sync;
                  s_d.phase = 2'h1;
               end else if (!sif.data_sync[`FESW_SR_READY]) begin
                  s_d.phase = 2'h0;
               end else if (s_q.op == fesw_pkg::FESW_OP_SUSPEND) begin
                  s_d.paused = sif.data_sync[`FESW_SR_PAUSED];
                  s_d.erasing = sif.data_sync[`FESW_SR_PAUSED];
                  s_d.rd_data = sif.data_sync;
                  s_d.phase = 2'h1;
               end else begin
                  // resume finished the erase
                  s_d.erasing = 1'b0;
                  s_d.rd_data = sif.data_sync;
                  s_d.phase = 2'h1;
               end
            end
         end
         fesw_pkg::FESW_RD_GAP: begin
            if (s_q.cnt == 8'h00) begin
               if (s_q.phase == 2'h1) begin
                  s_d.busy = 1'b0;
                  s_d.done = 1'b1;
                  s_d.st = fesw_pkg::FESW_IDLE;
               end else begin
                  s_d.cnt = T_STROBE;
                  s_d.st = fesw_pkg::FESW_RD_SETUP;
               end
            end
         end
         fesw_pkg::FESW_RECOVER: begin
            s_d.pd_n = 1'b1;
            if (s_q.cnt == 8'h00) begin
               s_d.busy = 1'b0;
               s_d.st = fesw_pkg::FESW_IDLE;
            end
         end
         default: begin
            s_d.st = fesw_pkg::FESW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.st <= fesw_pkg::FESW_RECOVER;
         s_q.op <= fesw_pkg::FESW_OP_NONE;
         s_q.cnt <= T_RECOVERY;
         s_q.busy <= 1'b1;
         // erase assumed running when this controller is brought up
         s_q.erasing <= 1'b1;
         s_q.in_array <= 1'b1;
         s_q.ce_n <= 1'b1;
         s_q.we_n <= 1'b1;
         s_q.oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign busy_o = s_q.busy;
   assign done_o = s_q.done;
   assign paused_o = s_q.paused;
   assign ignored_o = s_q.ignored;
   assign rd_data_o = s_q.rd_data;
   assign flash_addr_o = s_q.addr;
   assign flash_dq_o = s_q.dq;
   assign flash_dq_oe_o = s_q.dq_oe;
   assign flash_ce_n_o = s_q.ce_n;
   assign flash_we_n_o = s_q.we_n;
   assign flash_oe_n_o = s_q.oe_n;
   assign flash_oe_vhh_o = s_q.oe_vhh;
   assign powerdown_reset_n_o = s_q.pd_n;
endmodule // fesw_ctl
`default_nettype wire

// ==== design/fesw_pkg.sv ====
// types shared by the flash erase suspend/resume host controller
package fesw_pkg;
   typedef enum logic [3:0] {
      FESW_IDLE = 4'h0,
      FESW_SETUP = 4'h1,
      FESW_STROBE = 4'h3,
      FESW_HOLD = 4'h2,
      FESW_RD_SETUP = 4'h6,
      FESW_RD_SAMPLE = 4'h7,
      FESW_RD_GAP = 4'h5,
      FESW_RECOVER = 4'h4
   } fesw_state_t;
   typedef enum logic [1:0] {
      FESW_OP_SUSPEND = 2'h0,
      FESW_OP_RESUME = 2'h1,
      FESW_OP_READ = 2'h2,
      FESW_OP_NONE = 2'h3
   } fesw_op_t;
endpackage

// ==== design/fesw_regs.svh ====
// constants and timing counts for the flash erase suspend/resume host controller
// Behaviour
// - To pause a running block erase the controller writes the suspend code and the flash stops at a resumable point.
// - After suspend the controller polls the ready bit, toggling the output gate between reads so status refreshes.
// - While suspended the controller may write the read-array code and read any block but the interrupted one; read_addr_i is not checked against it.
// - To continue, the controller writes the resume code and the flash restarts the interrupted erase.
// - In chip-select-controlled writes write strobe is held low around the chip-select pulse and data is taken on its rise.
// - After powerdown reset returns high the controller waits the recovery interval before chip select falls for a write.
`ifndef FESW_REGS_SVH
`define FESW_REGS_SVH
`define FESW_CMD_SUSPEND 8'hb0
`define FESW_CMD_RESUME 8'hd0
`define FESW_CMD_READ_ARRAY 8'hff
`define FESW_CMD_READ_STATUS 8'h70
`define FESW_SR_READY 7
`define FESW_SR_PAUSED 6
`define FESW_CLK_PERIOD_NS 50
`define FESW_T_STROBE_NS 60
`define FESW_T_RECOVERY_NS 480
`define FESW_T_VHH_SETUP_NS 480
`define FESW_T_VHH_HOLD_NS 480
// least times round up
`define FESW_CYC(ns) (((ns) + `FESW_CLK_PERIOD_NS - 1) / `FESW_CLK_PERIOD_NS)
`endif

// ==== design/fesw_sync.sv ====
// two-flop synchroniser for the flash data bus
`timescale 1ns/10ps
`default_nettype none
module fesw_sync #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   fesw_sync_if.sync bus
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } fesw_sync_st_t;
   fesw_sync_st_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.meta = bus.data_raw;
      s_d.stable = s_q.meta;
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign bus.data_sync = s_q.stable;
endmodule // fesw_sync
`default_nettype wire

// ==== design/fesw_sync_if.sv ====
// pin bundle between the top and its input synchroniser
`timescale 1ns/10ps
`default_nettype none
interface fesw_sync_if;
   logic [7:0] data_raw;
   logic [7:0] data_sync;
   modport sync (input data_raw, output data_sync);
   modport top (output data_raw, input data_sync);
endinterface
`default_nettype wire

// ==== dv/fesw_ctl_checker.sv ====
// concurrent checks on the pins of the erase suspend controller
`timescale 1ns/10ps
`default_nettype none
module fesw_ctl_checker (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // user side
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic paused_o,
   input wire logic ignored_o,
   // flash side
   input wire logic [16:0] flash_addr_o,
   input wire logic [7:0] flash_dq_o,
   input wire logic flash_dq_oe_o,
   input wire logic flash_ce_n_o,
   input wire logic flash_we_n_o,
   input wire logic flash_oe_n_o,
   input wire logic flash_oe_vhh_o,
   input wire logic powerdown_reset_n_o
);
   // ==========
   // cycles since the flash left powerdown, saturating
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [3:0] pd_cnt_q;
   always_ff @(posedge sys_clk_i)
      pd_cnt_q <= !powerdown_reset_n_o ? 4'h0 : (pd_cnt_q == 4'hf ? pd_cnt_q : pd_cnt_q + 4'h1);
   a_recovery_wait: assert property ($fell(flash_ce_n_o) |-> pd_cnt_q >= 4'ha)
      else $error("chip select fell too soon after powerdown release");
   a_ce_capture: assert property ($rose(flash_ce_n_o) && $past(flash_oe_n_o) |->
      !flash_we_n_o && flash_dq_oe_o && $stable(flash_dq_o) && $stable(flash_addr_o))
      else $error("write data or address moved at chip select rise");
   a_we_hold: assert property ($rose(flash_ce_n_o) && !flash_we_n_o |=> !flash_we_n_o)
      else $error("write strobe released with chip select");
   a_one_strobe: assert property ($fell(flash_ce_n_o) |-> flash_we_n_o != flash_oe_n_o)
      else $error("chip select cycle is neither one write nor one read");
   a_cmd_codes: assert property ($rose(flash_ce_n_o) && !flash_we_n_o |->
      flash_dq_o inside {8'hb0, 8'hd0, 8'hff}) else $error("unexpected command byte");
   a_poll_toggle: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*6] ##1 flash_oe_n_o)
      else $error("output gate not toggled between status reads");
   a_no_contend: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
      else $error("data driven while flash outputs");
   a_vhh_setup: assert property ($fell(flash_we_n_o) && flash_oe_vhh_o |-> $past(flash_oe_vhh_o, 10))
      else $error("unlock voltage set up too late");
   // cycles the write strobe has stood high, saturating
   logic [3:0] we_hi_cnt_q;
   always_ff @(posedge sys_clk_i)
      we_hi_cnt_q <= (!rst_n_i || !flash_we_n_o) ? 4'h0 :
         (we_hi_cnt_q == 4'hf ? we_hi_cnt_q : we_hi_cnt_q + 4'h1);
   a_vhh_hold: assert property ($fell(flash_oe_vhh_o) |-> we_hi_cnt_q >= 4'ha)
      else $error("unlock voltage dropped too early");
   a_ignore_quiet: assert property (ignored_o |-> done_o && $stable(paused_o))
      else $error("ignored suspend not quiet");
   a_resume_busy: assert property ($fell(paused_o) |-> busy_o)
      else $error("pause cleared outside a resume");
endmodule // fesw_ctl_checker
bind fesw_ctl fesw_ctl_checker u_fesw_ctl_checker (.sys_clk_i, .rst_n_i, .busy_o, .done_o, .paused_o, .ignored_o,
   .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o, .flash_oe_vhh_o,
   .powerdown_reset_n_o);
`default_nettype wire

// ==== dv/fesw_ctl_tb.sv ====
// self-checking bench for the erase suspend controller
`timescale 1ns/10ps
`default_nettype none
module fesw_ctl_tb;
   localparam int ERASE = 400;
   logic sys_clk, rst_n, s_req, r_req, rd_req, unl, busy, done, paused, ign, dq_oe, ce_n, we_n, oe_n, unlock_high_voltage, pd_n;
   logic [16:0] r_addr, f_addr;
   logic [7:0] rd_data, dq_ctl, dq_mem;
   wire logic [7:0] dq_bus = dq_oe ? dq_ctl : dq_mem;
   int err_count = 0;
   int checks = 0;
   int n;
   fesw_ctl u_fesw_ctl (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .suspend_req_i(s_req), .resume_req_i(r_req),
      .read_req_i(rd_req), .read_addr_i(r_addr), .boot_unlock_i(unl), .busy_o(busy), .done_o(done),
      .paused_o(paused), .ignored_o(ign), .rd_data_o(rd_data), .flash_addr_o(f_addr), .flash_dq_o(dq_ctl),
      .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_bus), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n),
      .flash_oe_n_o(oe_n), .flash_oe_vhh_o(unlock_high_voltage), .powerdown_reset_n_o(pd_n));
   fesw_flash_model #(.SUSP_CYC(20), .ERASE_CYC(ERASE)) u_fesw_flash_model (.clk_i(sys_clk), .addr_i(f_addr),
      .dq_i(dq_bus), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .pd_n_i(pd_n), .dq_o(dq_mem));
   // ==========
   // shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic s, input logic r, input logic rd, input logic u, input logic [16:0] a);
      // requests are only taken in idle, so wait for busy to drop first
      #1;
      while (busy !== 1'b0) @(posedge sys_clk) #1;
      @(posedge sys_clk);
      {s_req, r_req, rd_req, unl, r_addr} <= {s, r, rd, u, a};
      @(posedge sys_clk);
      {s_req, r_req, rd_req} <= 3'h0;
      #1;
      for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge sys_clk) #1;
      chk(done, 1'b1);
   endtask
   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic t_recover();
      repeat (9) @(posedge sys_clk);
      #1 chk(busy, 1'b1);
      op(1'b0, 1'b0, 1'b1, 1'b0, 17'h12345);
      chk(rd_data, 8'h1f);
   endtask
   task automatic t_suspend();
      op(1'b1, 1'b0, 1'b0, 1'b1, 17'h00000);
      chk({paused, ign}, 8'h02);
      op(1'b1, 1'b0, 1'b0, 1'b0, 17'h00000);
      chk({paused, ign}, 8'h03);
   endtask
   task automatic t_read_through();
      op(1'b0, 1'b0, 1'b1, 1'b0, 17'h000ff);
      chk(rd_data, 8'ha5);
      op(1'b0, 1'b0, 1'b1, 1'b0, 17'h1ff00);
      chk(rd_data, 8'h5a);
   endtask
   task automatic t_resume();
      op(1'b0, 1'b1, 1'b0, 1'b0, 17'h00000);
      chk(paused, 1'b0);
      chk(n >= ERASE, 1'b1);
      op(1'b1, 1'b0, 1'b0, 1'b0, 17'h00000);
      chk({paused, ign}, 8'h01);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {rst_n, s_req, r_req, rd_req, unl, r_addr} = '0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_recover();
      t_suspend();
      t_read_through();
      t_resume();
      complete_run();
   end
   // a hung handshake is cut short well past the longest expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      complete_run();
   end
endmodule // fesw_ctl_tb
`default_nettype wire

// ==== dv/fesw_flash_model.sv ====
// behavioural flash device facing the erase suspend controller
`timescale 1ns/10ps
`default_nettype none
module fesw_flash_model #(
   parameter int SUSP_CYC = 20,
   parameter int ERASE_CYC = 400
) (
   // clock for command capture, bus sampling and engine time
   input wire logic clk_i,
   // flash pins
   input wire logic [16:0] addr_i,
   input wire logic [7:0] dq_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic pd_n_i,
   output logic [7:0] dq_o
);
   // ==========
   // command capture and engine
   logic erasing, paused, stat_mode, pend, ce_q;
   logic [7:0] last_q;
   int busy_cnt;
   // released bus shows the inverse of the last byte, never a kind settle value
   assign dq_o = (!ce_n_i && !oe_n_i) ? (stat_mode ? {busy_cnt == 0, paused, 6'h00}
                                                   : addr_i[7:0] ^ 8'h5a) : ~last_q;
   always @(posedge clk_i) begin
      ce_q <= ce_n_i;
      if (!ce_n_i && !oe_n_i) last_q <= dq_o;
      if (!pd_n_i) begin
         // an erase is taken as under way at every reset, as the controller assumes
         erasing <= 1'b1;
         paused <= 1'b0;
         stat_mode <= 1'b0;
         busy_cnt <= 0;
         last_q <= 8'h00;
      end else begin
         // one engine timer: completion status never shows before it runs out
         if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
         if (busy_cnt == 1 && pend) paused <= 1'b1;
         if (busy_cnt == 1 && !pend) erasing <= 1'b0;
         if (!ce_q && ce_n_i && !we_n_i) begin
            case (dq_i)
               8'hb0: if (erasing && !paused) begin
                  stat_mode <= 1'b1;
                  pend <= 1'b1;
                  busy_cnt <= SUSP_CYC;
               end
               8'hd0: if (paused) begin
                  stat_mode <= 1'b1;
                  pend <= 1'b0;
                  paused <= 1'b0;
                  busy_cnt <= ERASE_CYC;
               end
               8'hff: stat_mode <= 1'b0;
               default: ;
            endcase
         end
      end
   end
endmodule // fesw_flash_model
`default_nettype wire
